// file: eccr_params.svh
// Constants for the core clock and reset control block.
// What this block does
// - Frequency select picks 12, 16 or 24MHz.
// - PLL clock gate zero stops derived clock.
// - PLL power-off stops PLL and internal clocks.
// - Wait 100us for PLL after power-on.
// - Ring oscillator enable reads actual running state.
// - Sleep clears ring enable, wake sets it.
// - Source select: one PLL clock, zero ring.
// - Wake from sleep clears source select.
// - Reset delay counts machine cycles before pin release.
// - Either power-on reset restores register defaults, except the ring enable bit, which only the standby reset restores.
// - Standby power-up starts ring, waits, then fetches.
// - Standby reset held 20ms after supply good.
// - External clock usable only with main supply.
// - Ring oscillator keeps core clocked without main supply.
// - Supply-good fall starts ring, switches, raises interrupt.
`ifndef ECCR_PARAMS_SVH
`define ECCR_PARAMS_SVH
`define ECCR_ADDR_CLK_CTRL    16'h7F27
`define ECCR_ADDR_RST_COUNT   16'h7F2F
`define ECCR_RST_CLK_CTRL     8'h10
`define ECCR_RST_RST_COUNT    8'h00
`define ECCR_BIT_GATE         0
`define ECCR_BIT_PLL_OFF      1
`define ECCR_BIT_RING_ON      4
`define ECCR_BIT_SRC_SEL      5
`define ECCR_FSEL_LSB         6
`define ECCR_FREQ_12          2'h0
`define ECCR_FREQ_16          2'h1
`define ECCR_FREQ_24          2'h2
`define ECCR_CLK_MHZ          10
`define ECCR_PLL_SETTLE_US    100
`define ECCR_PLL_SETTLE_CYC   ((`ECCR_PLL_SETTLE_US * `ECCR_CLK_MHZ))
`define ECCR_POR_STRETCH_MS   20
`define ECCR_POR_STRETCH_CYC  (`ECCR_POR_STRETCH_MS * 1000 * `ECCR_CLK_MHZ)
`define ECCR_MAIN_WAIT_MS     1
`define ECCR_MAIN_WAIT_CYC    (`ECCR_MAIN_WAIT_MS * 1000 * `ECCR_CLK_MHZ)
`define ECCR_RING_SETTLE_CYC  16
`endif

// file: eccr_pkg.sv
// Types shared by the core clock and reset control block.
package eccr_pkg;
    typedef struct packed {
        logic [1:0] freq_sel;
        logic       src_pll;
        logic       ring_on;
        logic       pll_off;
        logic       gate;
    } eccr_clk_ctrl_t;

    typedef struct packed {
        logic       en;
        logic       wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } eccr_bus_req_t;

    typedef enum logic [1:0] {
        ECCR_ST_POR,
        ECCR_ST_RING_WAIT,
        ECCR_ST_RUN
    } eccr_boot_t;
endpackage : eccr_pkg

// file: eccr_top.sv
// Core clock selection, PLL control, start-up and reset-out release.
`timescale 1ns/10ps
`include "eccr_params.svh"
module eccr_top #(
    parameter int POR_STRETCH_CYC = `ECCR_POR_STRETCH_CYC,
    parameter int MAIN_WAIT_CYC   = `ECCR_MAIN_WAIT_CYC,
    parameter int PLL_SETTLE_CYC  = `ECCR_PLL_SETTLE_CYC
) (
    input  wire logic                   clk_sys,
    input  wire logic                   resetn,
    input  wire logic                   main_resetn,
    input  wire eccr_pkg::eccr_bus_req_t bus_req,
    output logic [7:0]                  bus_rdata,
    input  wire logic                   standby_supply_good,
    input  wire logic                   system_supply_good,
    input  wire logic                   core_sleep,
    input  wire logic                   core_wake,
    input  wire logic                   machine_cycle,
    input  wire logic                   internal_reset_out_bit,
    output logic                        reset_out_pin_n,
    output logic                        core_run,
    output logic                        ring_osc_run,
    output logic                        pll_run,
    output logic                        pll_stable,
    output logic                        pll_derived_clock_en,
    output logic                        core_on_pll,
    output logic [1:0]                  core_freq_select,
    output logic                        main_regs_ready,
    output logic                        power_fail_irq
);
    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic       sb_good;
    logic       sys_good;
    logic       main_rst_ok;
    logic       sys_good_d_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= {main_resetn, system_supply_good, standby_supply_good};
            sync2_r <= sync1_r;
        end
    end
    assign sb_good     = sync2_r[0];
    assign sys_good    = sync2_r[1];
    assign main_rst_ok = sync2_r[2];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sys_good_d_r <= 1'b0;
        end else begin
            sys_good_d_r <= sys_good;
        end
    end

    // A fall of the supply-good pin is seen only after both flops, so the
    // interrupt trails the pin by three edges; a glitch that spans no rising edge is missed.
    wire power_fail = sys_good_d_r && !sys_good;

    // ****************************************************************
    // Standby power-on reset stretch and start-up
    // ****************************************************************
    eccr_pkg::eccr_boot_t boot_r;
    logic [31:0]          boot_cnt_r;

    // Counting starts only once the standby supply-good pin is high, so a
    // slow supply ramp cannot shorten the stretch seen by the flash.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            boot_r     <= eccr_pkg::ECCR_ST_POR;
            boot_cnt_r <= 32'h0;
        end else begin
            case (boot_r)
                eccr_pkg::ECCR_ST_POR: begin
                    if (!sb_good) begin
                        boot_cnt_r <= 32'h0;
                    end else if (boot_cnt_r == 32'(POR_STRETCH_CYC - 1)) begin
                        boot_cnt_r <= 32'h0;
                        boot_r     <= eccr_pkg::ECCR_ST_RING_WAIT;
                    end else begin
                        boot_cnt_r <= boot_cnt_r + 32'h1;
                    end
                end
                eccr_pkg::ECCR_ST_RING_WAIT: begin
                    if (boot_cnt_r == 32'(`ECCR_RING_SETTLE_CYC - 1)) begin
                        boot_r <= eccr_pkg::ECCR_ST_RUN;
                    end else begin
                        boot_cnt_r <= boot_cnt_r + 32'h1;
                    end
                end
                eccr_pkg::ECCR_ST_RUN: begin
                    boot_r <= eccr_pkg::ECCR_ST_RUN;
                end
                default: begin
                    boot_r <= eccr_pkg::ECCR_ST_POR;
                end
            endcase
        end
    end

    // Core fetches from address zero when released out of reset.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            core_run <= 1'b0;
        end else begin
            core_run <= (boot_r == eccr_pkg::ECCR_ST_RUN);
        end
    end

    // ****************************************************************
    // Main-plane readiness window
    // ****************************************************************
    logic [31:0] main_cnt_r;

    // Firmware polls this before touching main-plane-cleared registers.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            main_cnt_r      <= 32'h0;
            main_regs_ready <= 1'b0;
        end else if (!(sys_good && main_rst_ok)) begin
            main_cnt_r      <= 32'h0;
            main_regs_ready <= 1'b0;
        end else if (main_cnt_r == 32'(MAIN_WAIT_CYC - 1)) begin
            main_regs_ready <= 1'b1;
        end else begin
            main_cnt_r <= main_cnt_r + 32'h1;
        end
    end

    // ****************************************************************
    // Register file
    // ****************************************************************
    eccr_pkg::eccr_clk_ctrl_t ctrl_r;
    logic [3:0]               rel_cycles_r;
    logic                     ring_on_r;

    // Both reset paths load one named pattern, so the standby and main
    // plane resets cannot drift apart. Bits 3:2 are not stored at all.
    localparam logic [7:0] CTRL_DEFAULT  = `ECCR_RST_CLK_CTRL;
    localparam logic [7:0] COUNT_DEFAULT = `ECCR_RST_RST_COUNT;
    localparam eccr_pkg::eccr_clk_ctrl_t CTRL_RESET = eccr_pkg::eccr_clk_ctrl_t'({
        CTRL_DEFAULT[`ECCR_FSEL_LSB +: 2], CTRL_DEFAULT[`ECCR_BIT_SRC_SEL],
        CTRL_DEFAULT[`ECCR_BIT_RING_ON], CTRL_DEFAULT[`ECCR_BIT_PLL_OFF],
        CTRL_DEFAULT[`ECCR_BIT_GATE]});
    wire wr_ctrl  = bus_req.en && bus_req.wr && (bus_req.addr == `ECCR_ADDR_CLK_CTRL);
    wire wr_count = bus_req.en && bus_req.wr && (bus_req.addr == `ECCR_ADDR_RST_COUNT);

    // Both power-on resets restore the control register defaults, except ring_on_r, which only resetn restores.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (!main_rst_ok) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl_r.freq_sel <= bus_req.wdata[`ECCR_FSEL_LSB +: 2];
                ctrl_r.src_pll  <= bus_req.wdata[`ECCR_BIT_SRC_SEL];
                ctrl_r.pll_off  <= bus_req.wdata[`ECCR_BIT_PLL_OFF];
                ctrl_r.gate     <= bus_req.wdata[`ECCR_BIT_GATE];
            end
            // Hardware events win over a firmware write in the same cycle.
            if (power_fail || core_wake) begin
                ctrl_r.src_pll <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rel_cycles_r <= COUNT_DEFAULT[3:0];
        end else if (!main_rst_ok) begin
            rel_cycles_r <= COUNT_DEFAULT[3:0];
        end else if (wr_count) begin
            rel_cycles_r <= bus_req.wdata[3:0];
        end
    end

    // The ring oscillator bit mirrors the running oscillator, not a latch.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ring_on_r <= CTRL_DEFAULT[`ECCR_BIT_RING_ON];
        end else if (power_fail || core_wake) begin
            ring_on_r <= 1'b1;
        end else if (core_sleep) begin
            ring_on_r <= 1'b0;
        end else if (wr_ctrl) begin
            ring_on_r <= bus_req.wdata[`ECCR_BIT_RING_ON];
        end
    end

    // Reads have no side effects, so firmware may poll either register freely.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bus_rdata <= 8'h00;
        end else if (bus_req.en && !bus_req.wr) begin
            case (bus_req.addr)
                `ECCR_ADDR_CLK_CTRL:
                    bus_rdata <= {ctrl_r.freq_sel, ctrl_r.src_pll, ring_on_r, 2'h0,
                                  ctrl_r.pll_off, ctrl_r.gate};
                `ECCR_ADDR_RST_COUNT: bus_rdata <= {4'h0, rel_cycles_r};
                default:              bus_rdata <= 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // PLL power and settle timer
    // ****************************************************************
    logic [31:0] pll_cnt_r;
    // The PLL reference exists only while the main plane is powered.
    wire pll_on = !ctrl_r.pll_off && sys_good;

    // Losing the main supply restarts the settle count from zero.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_cnt_r  <= 32'h0;
            pll_stable <= 1'b0;
        end else if (!pll_on) begin
            pll_cnt_r  <= 32'h0;
            pll_stable <= 1'b0;
        end else if (pll_cnt_r == 32'(PLL_SETTLE_CYC - 1)) begin
            pll_stable <= 1'b1;
        end else begin
            pll_cnt_r <= pll_cnt_r + 32'h1;
        end
    end

    // ****************************************************************
    // Glitch-free source switch
    // ****************************************************************
    // Each side's enable drops before the other rises, so the core never
    // sees two clocks or a clipped phase during a change of source.
    logic pll_sel_r;
    logic ring_sel_r;
    wire  want_pll = ctrl_r.src_pll && pll_stable && ctrl_r.gate;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_sel_r  <= 1'b0;
            ring_sel_r <= 1'b0;
        end else begin
            pll_sel_r  <= want_pll && !ring_sel_r;
            ring_sel_r <= !want_pll && !pll_sel_r && ring_on_r;
        end
    end

    // The clock-status outputs other than pll_stable, and the interrupt, are registered here, one edge behind their source.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_run              <= 1'b0;
            pll_derived_clock_en <= 1'b0;
            ring_osc_run         <= 1'b0;
            core_on_pll          <= 1'b0;
            core_freq_select     <= `ECCR_FREQ_12;
            power_fail_irq       <= 1'b0;
        end else begin
            pll_run              <= pll_on;
            pll_derived_clock_en <= pll_stable && ctrl_r.gate;
            ring_osc_run         <= ring_on_r;
            core_on_pll          <= pll_sel_r;
            core_freq_select     <= ctrl_r.freq_sel;
            power_fail_irq       <= power_fail;
        end
    end

    // ****************************************************************
    // Reset-out release counter
    // ****************************************************************
    logic [3:0] rel_cnt_r;
    logic       iro_d_r;
    logic       rel_busy_r;

    // A count of zero releases the pin at the first edge that sees the bit
    // clear; machine-cycle pulses that arrive while idle are ignored.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            iro_d_r         <= 1'b1;
            rel_busy_r      <= 1'b0;
            rel_cnt_r       <= 4'h0;
            reset_out_pin_n <= 1'b0;
        end else begin
            iro_d_r <= internal_reset_out_bit;
            if (internal_reset_out_bit) begin
                rel_busy_r      <= 1'b0;
                reset_out_pin_n <= 1'b0;
            end else if (iro_d_r) begin
                rel_cnt_r       <= rel_cycles_r;
                rel_busy_r      <= (rel_cycles_r != 4'h0);
                reset_out_pin_n <= (rel_cycles_r == 4'h0);
            end else if (rel_busy_r && machine_cycle) begin
                rel_cnt_r <= rel_cnt_r - 4'h1;
                if (rel_cnt_r == 4'h1) begin
                    rel_busy_r      <= 1'b0;
                    reset_out_pin_n <= 1'b1;
                end
            end
        end
    end
endmodule : eccr_top

// file: eccr_core_model.sv
// Behavioural model of the embedded core: machine cycles and sleep and wake pulses.
`timescale 1ns/10ps
module eccr_core_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] mc_div,
    output logic            machine_cycle,
    output logic            core_sleep,
    output logic            core_wake
);
    // ********
    // Core timing
    // ********
    logic [3:0] cnt_r;
    initial begin
        cnt_r = 4'h0;
        machine_cycle = 1'b0;
        core_sleep = 1'b0;
        core_wake = 1'b0;
    end
    // A larger divisor models a slow core, so the release count is seen at two rates.
    always @(negedge clk_sys) begin
        cnt_r <= (cnt_r >= mc_div) ? 4'h0 : cnt_r + 4'h1;
        machine_cycle <= (cnt_r == 4'h0);
    end
    task automatic pulse_sleep();
        @(negedge clk_sys);
        core_sleep = 1'b1;
        @(negedge clk_sys);
        core_sleep = 1'b0;
    endtask : pulse_sleep
    task automatic pulse_wake();
        @(negedge clk_sys);
        core_wake = 1'b1;
        @(negedge clk_sys);
        core_wake = 1'b0;
    endtask : pulse_wake
endmodule : eccr_core_model

// file: eccr_top_chk.sv
// Assertion checker for the core clock and reset control block.
`timescale 1ns/10ps
module eccr_top_chk #(
    parameter int PLL_SETTLE_CYC = 1000
) (
    input wire logic                    clk_sys,
    input wire logic                    resetn,
    input wire eccr_pkg::eccr_bus_req_t bus_req,
    input wire logic [7:0]              bus_rdata,
    input wire logic                    system_supply_good,
    input wire logic                    core_sleep,
    input wire logic                    internal_reset_out_bit,
    input wire logic                    reset_out_pin_n,
    input wire logic                    core_run,
    input wire logic                    pll_run,
    input wire logic                    pll_stable,
    input wire logic                    ring_osc_run,
    input wire logic                    core_on_pll,
    input wire logic [1:0]              core_freq_select,
    input wire logic                    power_fail_irq
);
    // ********
    // Checks
    // ********
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    logic [31:0] pll_age_r;
    // Cycles seen with the PLL powered; it saturates so a long run cannot wrap.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pll_age_r <= 32'h0;
        end else if (!pll_run) begin
            pll_age_r <= 32'h0;
        end else if (pll_age_r != 32'hFFFFFFFF) begin
            pll_age_r <= pll_age_r + 32'h1;
        end
    end
    wire logic acc_ctl = bus_req.en && bus_req.addr == 16'h7F27;
    wire logic wr_ctl = acc_ctl && bus_req.wr;
    wire logic rd_ctl = acc_ctl && !bus_req.wr;
    wire logic rd_cnt = bus_req.en && !bus_req.wr && bus_req.addr == 16'h7F2F;
    AST_FREQ: assert property (wr_ctl |-> ##2 core_freq_select == $past(bus_req.wdata[7:6], 2))
        else $error("frequency select did not follow the write");
    AST_CTL_READ: assert property (rd_ctl |=> bus_rdata[3:2] == 2'h0 && bus_rdata[4] == ring_osc_run)
        else $error("control read back wrong");
    AST_CNT_READ: assert property (rd_cnt |=> bus_rdata[7:4] == 4'h0)
        else $error("count upper bits not zero");
    AST_PLL_OFF: assert property (wr_ctl && bus_req.wdata[1] |-> ##[1:3] !pll_run)
        else $error("pll kept running when powered off");
    AST_PLL_SETTLE: assert property (pll_run |-> pll_stable == (pll_age_r >= 32'(PLL_SETTLE_CYC - 1)))
        else $error("pll settle time wrong");
    AST_RST_HOLD: assert property (internal_reset_out_bit |=> !reset_out_pin_n)
        else $error("reset out released while held");
    AST_SLEEP: assert property (core_sleep |-> ##[1:2] !ring_osc_run)
        else $error("ring kept running in sleep");
    AST_PF_IRQ: assert property ($fell(system_supply_good) |-> ##[1:8] power_fail_irq)
        else $error("no power fail interrupt");
    AST_IRQ_PULSE: assert property (power_fail_irq |=> !power_fail_irq)
        else $error("power fail interrupt longer than a cycle");
    AST_PF_RING: assert property (power_fail_irq |-> ##[0:6] !core_on_pll && ring_osc_run)
        else $error("core not moved to ring on power fail");
    cover property ($rose(core_run));
    cover property ($rose(reset_out_pin_n));
    cover property (power_fail_irq);
endmodule : eccr_top_chk
bind eccr_top eccr_top_chk #(.PLL_SETTLE_CYC(PLL_SETTLE_CYC)) u_chk (
    .clk_sys(clk_sys), .resetn(resetn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .system_supply_good(system_supply_good), .core_sleep(core_sleep),
    .internal_reset_out_bit(internal_reset_out_bit), .reset_out_pin_n(reset_out_pin_n),
    .core_run(core_run), .pll_run(pll_run), .pll_stable(pll_stable),
    .ring_osc_run(ring_osc_run), .core_on_pll(core_on_pll),
    .core_freq_select(core_freq_select), .power_fail_irq(power_fail_irq)
);

// file: ec_clock_reset_control_test.sv
// Self-checking testbench for the core clock and reset control block.
`timescale 1ns/10ps
module ec_clock_reset_control_test;
    // ********
    // Bench
    // ********
    logic clk_sys = 1'b0, resetn = 1'b0, main_resetn = 1'b1, sgood = 1'b1, pgood = 1'b1;
    logic irst = 1'b0, mc, slp, wak, pin_n, crun, ring, prun, pstab, gate, onpll, mrdy, irq;
    logic [3:0] mc_div = 4'h3;
    logic [1:0] fsel;
    logic [7:0] rdata;
    eccr_pkg::eccr_bus_req_t bus_req = '0;
    int errors = 0, checks_done = 0, cyc = 0, n, k;
    always #50 clk_sys = ~clk_sys;
    eccr_core_model core (.clk_sys(clk_sys), .mc_div(mc_div), .machine_cycle(mc),
        .core_sleep(slp), .core_wake(wak));
    eccr_top #(.POR_STRETCH_CYC(20), .MAIN_WAIT_CYC(10), .PLL_SETTLE_CYC(8)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .main_resetn(main_resetn), .bus_req(bus_req),
        .bus_rdata(rdata), .standby_supply_good(sgood), .system_supply_good(pgood),
        .core_sleep(slp), .core_wake(wak), .machine_cycle(mc), .internal_reset_out_bit(irst),
        .reset_out_pin_n(pin_n), .core_run(crun), .ring_osc_run(ring), .pll_run(prun),
        .pll_stable(pstab), .pll_derived_clock_en(gate), .core_on_pll(onpll),
        .core_freq_select(fsel), .main_regs_ready(mrdy), .power_fail_irq(irq));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus_req = '{en: 1'b1, wr: w, addr: a, wdata: d};
        @(negedge clk_sys);
        bus_req.en = 1'b0;
    endtask : bus
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        bus(1'b0, a, 8'h00);
        @(negedge clk_sys);
        chk(what, rdata, exp);
    endtask : rd
    task automatic test_boot();
        for (n = 1; n < 100 && !crun; n++) @(negedge clk_sys);
        chk("boot_cycles", (n >= 37 && n <= 40), 1);
        for (k = 0; k < 100 && !mrdy; k++) @(negedge clk_sys);
        chk("main_ready", mrdy, 1'b1);
        rd(16'h7F27, 8'h10, "ctl_default");
        rd(16'h7F2F, 8'h00, "cnt_default");
        rd(16'h7F00, 8'h00, "unmapped");
    endtask : test_boot
    task automatic test_freq();
        for (int f = 0; f < 3; f++) begin
            bus(1'b1, 16'h7F27, {f[1:0], 6'h3D});
            rd(16'h7F27, {f[1:0], 6'h31}, "ctl_rb");
            chk("freq", fsel, f[1:0]);
        end
        repeat (20) @(negedge clk_sys);
        chk("on_pll", {gate, onpll}, 2'h3);
        bus(1'b1, 16'h7F27, 8'h10);
        repeat (6) @(negedge clk_sys);
        chk("on_ring", {gate, onpll, ring}, 3'h1);
        bus(1'b1, 16'h7F27, 8'h01);
        repeat (3) @(negedge clk_sys);
        chk("ring_off", ring, 1'b0);
    endtask : test_freq
    task automatic test_release();
        logic [3:0] c;
        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? 4'h0 : ((i == 1) ? 4'h3 : 4'hF);
            mc_div = (c == 4'h3) ? 4'h1 : 4'h5;
            bus(1'b1, 16'h7F2F, {4'hF, c});
            rd(16'h7F2F, {4'h0, c}, "cnt_rb");
            irst = 1'b1;
            repeat (3) @(negedge clk_sys);
            chk("pin_held", pin_n, 1'b0);
            irst = 1'b0;
            n = 0;
            for (k = 0; k < 200; k++) begin
                @(posedge clk_sys);
                if (k >= 1 && mc) n++;
                #1;
                if (pin_n) break;
            end
            chk("release", n[7:0], {4'h0, c});
        end
    endtask : test_release
    task automatic test_pll();
        bus(1'b1, 16'h7F27, 8'h13);
        repeat (3) @(negedge clk_sys);
        chk("pll_off", {prun, pstab}, 2'h0);
        bus(1'b1, 16'h7F27, 8'h11);
        for (n = 0; n < 50 && !pstab; n++) @(negedge clk_sys);
        chk("pll_settle", (n >= 7 && n < 50), 1);
    endtask : test_pll
    task automatic test_sleep();
        bus(1'b1, 16'h7F27, 8'h31);
        core.pulse_sleep();
        repeat (3) @(negedge clk_sys);
        chk("sleep_ring", ring, 1'b0);
        core.pulse_wake();
        repeat (3) @(negedge clk_sys);
        rd(16'h7F27, 8'h11, "wake_ctl");
    endtask : test_sleep
    task automatic test_pfail();
        bus(1'b1, 16'h7F27, 8'h21);
        repeat (20) @(negedge clk_sys);
        pgood = 1'b0;
        for (n = 0; n < 20 && !irq; n++) @(negedge clk_sys);
        chk("pf_irq", irq, 1'b1);
        repeat (8) @(negedge clk_sys);
        chk("pf_ring", {onpll, ring}, 2'h1);
        rd(16'h7F27, 8'h11, "pf_ctl");
        pgood = 1'b1;
        main_resetn = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk("main_not_ready", mrdy, 1'b0);
        main_resetn = 1'b1;
        for (n = 0; n < 50 && !mrdy; n++) @(negedge clk_sys);
        chk("main_wait", (n >= 10 && n <= 13), 1'b1);
        rd(16'h7F27, 8'h10, "main_ctl");
        rd(16'h7F2F, 8'h00, "main_cnt");
    endtask : test_pfail
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        resetn = 1'b1;
        test_boot();
        test_freq();
        test_release();
        test_pll();
        test_sleep();
        test_pfail();
        report_and_stop();
    end
endmodule : ec_clock_reset_control_test
